// >>> nfc_pkg.sv
package nfc_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_CS_NS = 20;
    localparam int T_WP_NS = 12;
    localparam int T_WH_NS = 10;
    localparam int T_REA_NS = 20;
    localparam int T_REH_NS = 10;
    localparam int T_ADL_NS = 100;
    localparam int T_WHR_NS = 60;
    localparam int T_WB_NS = 100;
    // Extra cycle covers the pin register
    localparam logic [7:0] SU_CYC = 8'((T_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WH_CYC = 8'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] REA_CYC = 8'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] REH_CYC = 8'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Gap also covers the shorter write-to-read turnaround
    localparam logic [7:0] GAP_CYC = 8'((T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    ////////////////////////////////////////////////////////////////////////////
    // Command bytes
    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h30;
    localparam logic [7:0] CMD_PROG1 = 8'h80;
    localparam logic [7:0] CMD_PROG2 = 8'h10;
    localparam logic [7:0] CMD_ERASE1 = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] ID_ADDR = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Page layout and counts
    localparam logic [11:0] PAGE_LAST = 12'h083F;
    localparam logic [11:0] ID_LAST = 12'h0004;
    localparam logic [11:0] STAT_LAST = 12'h0000;
    localparam logic [11:0] MAIN_END = 12'h0800;
    localparam logic [8:0] SECT_MAIN_LAST = 9'h1FF;
    localparam logic [1:0] AB_FIRST_COL = 2'h0;
    localparam logic [1:0] AB_FIRST_ROW = 2'h2;
    localparam logic [1:0] AB_LAST = 2'h3;
    localparam int STATUS_FAIL_BIT = 0;
    localparam int BLOCKS = 1024;
    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {OP_READ_ID, OP_READ_PAGE, OP_PROGRAM, OP_ERASE} nfc_op_type;
    typedef enum logic [3:0] {ST_IDLE, ST_CMD1, ST_ADDR, ST_GAP, ST_WDATA, ST_CMD2, ST_BUSY, ST_STAT,
        ST_RDATA, ST_DONE} nfc_st_type;
    typedef struct packed {
        nfc_op_type op;
        logic [15:0] row;
    } nfc_req_type;
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic io_oe_n;
        logic [7:0] io_out;
    } nfc_pins_type;
    typedef struct packed {
        logic [8:0] lp1;
        logic [8:0] lp0;
        logic [7:0] cp;
    } nfc_ecc_type;
    typedef struct packed {
        nfc_st_type st;
        nfc_st_type ret;
        nfc_op_type op;
        logic [15:0] row;
        logic [1:0] ph;
        logic [7:0] tmr;
        logic [11:0] cnt;
        logic [1:0] ab;
        nfc_pins_type pins;
        logic [7:0] dout;
        logic dout_v;
        logic done;
        logic fail;
        logic refused;
        nfc_ecc_type acc;
        nfc_ecc_type ecc;
        logic ecc_v;
        logic last_v;
        logic [9:0] last_blk;
        logic [5:0] last_pg;
        logic [BLOCKS-1:0] bad;
    } nfc_state_type;
endpackage

// >>> nfc_host.sv
`timescale 1ns/1ps
// Function
// - Program data written as whole pages
// - Never alter sectors by random data input
// - Program pages ascending within a block (order checked only against the last programmed block)
// - Ascending run may start at any page
// - Chip select may drop during data loading
// - Address bytes: column low, column high, rows
// - Identification read starts with 90H
// - Read status after program and erase
// - Retired blocks recorded, never programmed again
// - Read data gets error correction code
module nfc_host (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic REQ_VALID_IN,
    input wire nfc_pkg::nfc_req_type REQ_IN,
    output logic REQ_READY_OUT,
    input wire logic DIN_VALID_IN,
    input wire logic [7:0] DIN_IN,
    output logic DIN_READY_OUT,
    output logic [7:0] DOUT_OUT,
    output logic DOUT_VALID_OUT,
    output nfc_pkg::nfc_ecc_type ECC_OUT,
    output logic ECC_VALID_OUT,
    output logic DONE_OUT,
    output logic FAIL_OUT,
    output logic REFUSED_OUT,
    output nfc_pkg::nfc_pins_type NAND_PINS_OUT,
    input wire logic [7:0] NAND_IO_IN,
    input wire logic NAND_RB_IN
);
    nfc_pkg::nfc_state_type r_reg;
    nfc_pkg::nfc_state_type r_next;
    logic wr_fin;
    logic rd_fin;
    logic rd_take;
    logic prog_bad;
    logic prog_order;
    ////////////////////////////////////////////////////////////////////////////
    // Pin cycle, ECC and address helpers
    function automatic nfc_pkg::nfc_state_type wr_step(input nfc_pkg::nfc_state_type s, input logic [7:0] b,
        input logic cle, input logic ale);
        nfc_pkg::nfc_state_type t;
        t = s;
        t.pins.ce_n = 1'b0;
        t.pins.cle = cle;
        t.pins.ale = ale;
        t.pins.re_n = 1'b1;
        t.pins.io_oe_n = 1'b0;
        t.pins.io_out = b;
        t.tmr = s.tmr + 8'h01;
        unique case (s.ph)
            2'h0: if (s.tmr == nfc_pkg::SU_CYC - 8'h01) begin
                t.ph = 2'h1;
                t.tmr = 8'h00;
            end
            2'h1: if (s.tmr == nfc_pkg::WP_CYC - 8'h01) begin
                t.ph = 2'h2;
                t.tmr = 8'h00;
            end
            default: if (s.tmr == nfc_pkg::WH_CYC - 8'h01) begin
                t.ph = 2'h0;
                t.tmr = 8'h00;
            end
        endcase
        t.pins.we_n = (t.ph != 2'h1);
        return t;
    endfunction

    function automatic nfc_pkg::nfc_state_type rd_step(input nfc_pkg::nfc_state_type s);
        nfc_pkg::nfc_state_type t;
        t = s;
        t.pins = '{ce_n: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe_n: 1'b1, io_out: s.pins.io_out};
        t.tmr = s.tmr + 8'h01;
        unique case (s.ph)
            2'h0: begin
                t.ph = 2'h1;
                t.tmr = 8'h00;
            end
            2'h1: if (s.tmr == nfc_pkg::REA_CYC - 8'h01) begin
                t.ph = 2'h2;
                t.tmr = 8'h00;
            end
            default: if (s.tmr == nfc_pkg::REH_CYC - 8'h01) begin
                t.ph = 2'h0;
                t.tmr = 8'h00;
            end
        endcase
        t.pins.re_n = (t.ph != 2'h1);
        return t;
    endfunction

    function automatic nfc_pkg::nfc_state_type ecc_byte(input nfc_pkg::nfc_state_type s, input logic [7:0] b);
        nfc_pkg::nfc_state_type t;
        logic bp;
        t = s;
        bp = ^b;
        if (s.cnt < nfc_pkg::MAIN_END) begin
            for (int i = 0; i < 9; i++) begin
                if (s.cnt[i]) begin
                    t.acc.lp1[i] = t.acc.lp1[i] ^ bp;
                end else begin
                    t.acc.lp0[i] = t.acc.lp0[i] ^ bp;
                end
            end
            t.acc.cp = t.acc.cp ^ b;
            if (s.cnt[8:0] == nfc_pkg::SECT_MAIN_LAST) begin
                t.ecc = t.acc;
                t.ecc_v = 1'b1;
                t.acc = '0;
            end
        end
        return t;
    endfunction

    function automatic logic [7:0] addr_byte(input logic [1:0] ab, input logic [15:0] row);
        logic [7:0] v;
        v = 8'h00;
        if (ab == nfc_pkg::AB_FIRST_ROW) begin
            v = row[7:0];
        end else if (ab == nfc_pkg::AB_LAST) begin
            v = row[15:8];
        end
        return v;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Next state
    assign wr_fin = (r_reg.ph == 2'h2) && (r_reg.tmr == nfc_pkg::WH_CYC - 8'h01);
    assign rd_fin = (r_reg.ph == 2'h2) && (r_reg.tmr == nfc_pkg::REH_CYC - 8'h01);
    assign rd_take = (r_reg.ph == 2'h1) && (r_reg.tmr == nfc_pkg::REA_CYC - 8'h01);
    assign REQ_READY_OUT = (r_reg.st == nfc_pkg::ST_IDLE);
    assign DIN_READY_OUT = (r_reg.st == nfc_pkg::ST_WDATA) && (r_reg.ph == 2'h0) && (r_reg.tmr == 8'h00);
    assign prog_bad = (REQ_IN.op inside {nfc_pkg::OP_PROGRAM, nfc_pkg::OP_ERASE}) && r_reg.bad[REQ_IN.row[15:6]];
    assign prog_order = (REQ_IN.op == nfc_pkg::OP_PROGRAM) && r_reg.last_v &&
        (REQ_IN.row[15:6] == r_reg.last_blk) && (REQ_IN.row[5:0] <= r_reg.last_pg);

    always_comb begin
        r_next = r_reg;
        r_next.dout_v = 1'b0;
        r_next.done = 1'b0;
        r_next.ecc_v = 1'b0;
        unique case (r_reg.st)
            nfc_pkg::ST_IDLE: begin
                r_next.pins = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe_n: 1'b1,
                    io_out: 8'h00};
                if (REQ_VALID_IN) begin
                    r_next.op = REQ_IN.op;
                    r_next.row = REQ_IN.row;
                    r_next.fail = 1'b0;
                    r_next.refused = prog_bad || prog_order;
                    r_next.cnt = 12'h000;
                    r_next.ph = 2'h0;
                    r_next.tmr = 8'h00;
                    r_next.acc = '0;
                    r_next.ab = (REQ_IN.op == nfc_pkg::OP_ERASE) ? nfc_pkg::AB_FIRST_ROW : nfc_pkg::AB_FIRST_COL;
                    r_next.st = (prog_bad || prog_order) ? nfc_pkg::ST_DONE : nfc_pkg::ST_CMD1;
                    if (REQ_IN.op == nfc_pkg::OP_PROGRAM && !(prog_bad || prog_order)) begin
                        r_next.last_v = 1'b1;
                        r_next.last_blk = REQ_IN.row[15:6];
                        r_next.last_pg = REQ_IN.row[5:0];
                    end
                    if (REQ_IN.op == nfc_pkg::OP_ERASE && !prog_bad && REQ_IN.row[15:6] == r_reg.last_blk) begin
                        r_next.last_v = 1'b0;
                    end
                end
            end
            nfc_pkg::ST_CMD1: begin
                unique case (r_reg.op)
                    nfc_pkg::OP_READ_ID: r_next = wr_step(r_next, nfc_pkg::CMD_READ_ID, 1'b1, 1'b0);
                    nfc_pkg::OP_READ_PAGE: r_next = wr_step(r_next, nfc_pkg::CMD_READ1, 1'b1, 1'b0);
                    nfc_pkg::OP_PROGRAM: r_next = wr_step(r_next, nfc_pkg::CMD_PROG1, 1'b1, 1'b0);
                    nfc_pkg::OP_ERASE: r_next = wr_step(r_next, nfc_pkg::CMD_ERASE1, 1'b1, 1'b0);
                endcase
                if (wr_fin) begin
                    r_next.st = nfc_pkg::ST_ADDR;
                end
            end
            nfc_pkg::ST_ADDR: begin
                if (r_reg.op == nfc_pkg::OP_READ_ID) begin
                    r_next = wr_step(r_next, nfc_pkg::ID_ADDR, 1'b0, 1'b1);
                end else begin
                    r_next = wr_step(r_next, addr_byte(r_reg.ab, r_reg.row), 1'b0, 1'b1);
                end
                if (wr_fin) begin
                    r_next.ab = r_reg.ab + 2'h1;
                    if (r_reg.op == nfc_pkg::OP_READ_ID || r_reg.ab == nfc_pkg::AB_LAST) begin
                        r_next.st = (r_reg.op inside {nfc_pkg::OP_READ_ID, nfc_pkg::OP_PROGRAM}) ?
                            nfc_pkg::ST_GAP : nfc_pkg::ST_CMD2;
                        r_next.ret = (r_reg.op == nfc_pkg::OP_PROGRAM) ? nfc_pkg::ST_WDATA : nfc_pkg::ST_RDATA;
                    end
                end
            end
            nfc_pkg::ST_GAP: begin
                r_next.pins.we_n = 1'b1;
                r_next.pins.re_n = 1'b1;
                r_next.pins.io_oe_n = 1'b1;
                r_next.pins.cle = 1'b0;
                r_next.pins.ale = 1'b0;
                r_next.tmr = r_reg.tmr + 8'h01;
                if (r_reg.tmr == nfc_pkg::GAP_CYC - 8'h01) begin
                    r_next.tmr = 8'h00;
                    r_next.st = r_reg.ret;
                end
            end
            nfc_pkg::ST_WDATA: begin
                if (DIN_READY_OUT && !DIN_VALID_IN) begin
                    r_next.pins.ce_n = 1'b1;
                    r_next.pins.io_oe_n = 1'b1;
                end else begin
                    r_next = wr_step(r_next, DIN_READY_OUT ? DIN_IN : r_reg.pins.io_out, 1'b0, 1'b0);
                    if (DIN_READY_OUT) begin
                        r_next = ecc_byte(r_next, DIN_IN);
                    end
                end
                if (wr_fin) begin
                    r_next.cnt = r_reg.cnt + 12'h001;
                    if (r_reg.cnt == nfc_pkg::PAGE_LAST) begin
                        r_next.st = nfc_pkg::ST_CMD2;
                    end
                end
            end
            nfc_pkg::ST_CMD2: begin
                unique case (r_reg.op)
                    nfc_pkg::OP_READ_PAGE: r_next = wr_step(r_next, nfc_pkg::CMD_READ2, 1'b1, 1'b0);
                    nfc_pkg::OP_ERASE: r_next = wr_step(r_next, nfc_pkg::CMD_ERASE2, 1'b1, 1'b0);
                    default: r_next = wr_step(r_next, nfc_pkg::CMD_PROG2, 1'b1, 1'b0);
                endcase
                if (wr_fin) begin
                    r_next.st = nfc_pkg::ST_BUSY;
                end
            end
            nfc_pkg::ST_BUSY: begin
                r_next.pins.cle = 1'b0;
                r_next.pins.io_oe_n = 1'b1;
                if (r_reg.tmr != nfc_pkg::WB_CYC) begin
                    r_next.tmr = r_reg.tmr + 8'h01;
                end else if (NAND_RB_IN) begin
                    r_next.tmr = 8'h00;
                    r_next.cnt = 12'h000;
                    r_next.st = (r_reg.op == nfc_pkg::OP_READ_PAGE) ? nfc_pkg::ST_GAP : nfc_pkg::ST_STAT;
                    r_next.ret = nfc_pkg::ST_RDATA;
                end
            end
            nfc_pkg::ST_STAT: begin
                r_next = wr_step(r_next, nfc_pkg::CMD_STATUS, 1'b1, 1'b0);
                if (wr_fin) begin
                    r_next.st = nfc_pkg::ST_GAP;
                end
            end
            nfc_pkg::ST_RDATA: begin
                r_next = rd_step(r_next);
                if (rd_take) begin
                    if (r_reg.op inside {nfc_pkg::OP_PROGRAM, nfc_pkg::OP_ERASE}) begin
                        r_next.fail = NAND_IO_IN[nfc_pkg::STATUS_FAIL_BIT];
                        if (NAND_IO_IN[nfc_pkg::STATUS_FAIL_BIT]) begin
                            r_next.bad[r_reg.row[15:6]] = 1'b1;
                        end
                    end else begin
                        r_next.dout = NAND_IO_IN;
                        r_next.dout_v = 1'b1;
                        if (r_reg.op == nfc_pkg::OP_READ_PAGE) begin
                            r_next = ecc_byte(r_next, NAND_IO_IN);
                        end
                    end
                end
                if (rd_fin) begin
                    r_next.cnt = r_reg.cnt + 12'h001;
                    if ((r_reg.op == nfc_pkg::OP_READ_ID && r_reg.cnt == nfc_pkg::ID_LAST) ||
                        (r_reg.op == nfc_pkg::OP_READ_PAGE && r_reg.cnt == nfc_pkg::PAGE_LAST) ||
                        (r_reg.op inside {nfc_pkg::OP_PROGRAM, nfc_pkg::OP_ERASE} && r_reg.cnt == nfc_pkg::STAT_LAST)) begin
                        r_next.st = nfc_pkg::ST_DONE;
                    end
                end
            end
            nfc_pkg::ST_DONE: begin
                r_next.done = 1'b1;
                r_next.st = nfc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r_reg <= '0;
            r_reg.pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe_n: 1'b1, io_out: 8'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    assign NAND_PINS_OUT = r_reg.pins;
    assign DOUT_OUT = r_reg.dout;
    assign DOUT_VALID_OUT = r_reg.dout_v;
    assign ECC_OUT = r_reg.ecc;
    assign ECC_VALID_OUT = r_reg.ecc_v;
    assign DONE_OUT = r_reg.done;
    assign FAIL_OUT = r_reg.fail;
    assign REFUSED_OUT = r_reg.refused;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    AST_WE_WIDTH: assert property ($fell(r_reg.pins.we_n) |-> (!r_reg.pins.we_n) [*3] ##1 r_reg.pins.we_n)
        else $error("write strobe low width wrong");
    AST_RE_WIDTH: assert property ($fell(r_reg.pins.re_n) |-> (!r_reg.pins.re_n) [*5] ##1 r_reg.pins.re_n)
        else $error("read strobe low width wrong");
    AST_ID_CMD: assert property ((r_reg.st == nfc_pkg::ST_CMD1 && r_reg.op == nfc_pkg::OP_READ_ID
        && !r_reg.pins.we_n) |-> r_reg.pins.cle && r_reg.pins.io_out == nfc_pkg::CMD_READ_ID)
        else $error("identification command byte wrong");
    AST_ID_ADDR: assert property ((r_reg.st == nfc_pkg::ST_ADDR && r_reg.op == nfc_pkg::OP_READ_ID
        && !r_reg.pins.we_n) |-> r_reg.pins.ale && r_reg.pins.io_out == nfc_pkg::ID_ADDR)
        else $error("identification address not zero");
    AST_ROW_HI: assert property ((r_reg.st == nfc_pkg::ST_ADDR && r_reg.ab == nfc_pkg::AB_LAST
        && !r_reg.pins.we_n) |-> r_reg.pins.io_out == r_reg.row[15:8])
        else $error("second row byte wrong");
    AST_ORDER_REFUSE: assert property ((REQ_READY_OUT && REQ_VALID_IN && prog_order)
        |=> r_reg.st == nfc_pkg::ST_DONE && r_reg.refused ##1 DONE_OUT && !r_reg.pins.we_n == 1'b0)
        else $error("out of order program not refused");
    AST_BAD_REFUSE: assert property ((REQ_READY_OUT && REQ_VALID_IN && prog_bad) |=>
        r_reg.refused ##1 DONE_OUT)
        else $error("retired block not refused");
    AST_STATUS_NEXT: assert property (($past(r_reg.st) == nfc_pkg::ST_BUSY && r_reg.st != nfc_pkg::ST_BUSY
        && r_reg.op != nfc_pkg::OP_READ_PAGE) |-> r_reg.st == nfc_pkg::ST_STAT)
        else $error("status read skipped");
    AST_CE_RELEASE: assert property ((DIN_READY_OUT && !DIN_VALID_IN) |=> r_reg.pins.ce_n)
        else $error("chip select held while starved");
    AST_FAIL_MARK: assert property ((DONE_OUT && FAIL_OUT) |-> r_reg.bad[r_reg.row[15:6]])
        else $error("failed block not retired");
    AST_ECC_SECTOR: assert property (ECC_VALID_OUT |-> $past(r_reg.cnt[8:0]) == nfc_pkg::SECT_MAIN_LAST)
        else $error("sector code at wrong column");

    COV_ID: cover property (DONE_OUT && r_reg.op == nfc_pkg::OP_READ_ID);
    COV_PROG: cover property (DONE_OUT && r_reg.op == nfc_pkg::OP_PROGRAM && !FAIL_OUT);
    COV_FAIL: cover property (DONE_OUT && FAIL_OUT);
    COV_REFUSE: cover property (DONE_OUT && REFUSED_OUT);
endmodule // nfc_host

// >>> nfc_dev.sv
`timescale 1ns/1ps
// Flash device model with one page buffer
// Arbitrary identity default
module nfc_dev #(parameter logic [39:0] ID_VAL = 40'h5A6B_7C8D_9E) (
    input wire logic CLK_IN,
    input wire nfc_pkg::nfc_pins_type PINS_IN,
    input wire logic [9:0] FAIL_BLK_IN,
    output logic [7:0] IO_OUT,
    output logic RB_OUT
);
    logic [7:0] mem [0:2111];
    logic [7:0] adr [0:3];
    logic [7:0] cmd = 8'h00;
    logic [15:0] row;
    logic we_q = 1'b1, re_q = 1'b1, fail = 1'b0;
    int na = 0, col = 0, busy = 0;
    nfc_pkg::nfc_pins_type p;
    assign p = PINS_IN;
    assign RB_OUT = busy == 0;
    assign row = na == 2 ? {adr[1], adr[0]} : {adr[3], adr[2]};
    initial IO_OUT = 8'h00;
    always @(posedge CLK_IN) begin
        we_q <= p.we_n;
        re_q <= p.re_n;
        if (busy > 0) busy <= busy - 1;
        if (!we_q && p.we_n && !p.ce_n) begin
            if (p.cle) begin
                cmd <= p.io_out;
                na <= 0;
                col <= 0;
                if (p.io_out == 8'h10 || p.io_out == 8'hD0 || p.io_out == 8'h30) busy <= 40;
                if (p.io_out == 8'h10 || p.io_out == 8'hD0) fail <= row[15:6] == FAIL_BLK_IN;
            end else if (p.ale) begin
                adr[na] <= p.io_out;
                na <= na + 1;
            end else begin
                mem[col] <= p.io_out;
                col <= col + 1;
            end
        end
        if (re_q && !p.re_n && !p.ce_n) begin
            IO_OUT <= cmd == 8'h70 ? {7'h00, fail} : cmd == 8'h90 ? ID_VAL[39 - 8 * col -: 8] : mem[col];
            col <= col + 1;
        end else if (p.re_n) IO_OUT <= ~IO_OUT;
    end
endmodule // nfc_dev

// >>> nfc_host_test.sv
`timescale 1ns/1ps
module nfc_host_test;
    // Arbitrary identity bytes
    localparam logic [39:0] ID_VAL = 40'hA53C_1122_33;
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    logic REQ_VALID_IN = 1'b0;
    logic DIN_VALID_IN = 1'b0;
    logic [7:0] DIN_IN = 8'h00;
    logic [9:0] fail_blk = 10'h3FF;
    nfc_pkg::nfc_req_type REQ_IN = '0;
    nfc_pkg::nfc_ecc_type ECC_OUT, ecc_seen;
    nfc_pkg::nfc_pins_type NAND_PINS_OUT;
    logic REQ_READY_OUT, DIN_READY_OUT, DOUT_VALID_OUT, ECC_VALID_OUT, DONE_OUT, FAIL_OUT, REFUSED_OUT, rb;
    logic [7:0] DOUT_OUT, dev_io, io;
    logic [7:0] outb [0:2111];
    int num_errors = 0, samples_checked = 0, nout, necc, k;
    assign io = NAND_PINS_OUT.io_oe_n ? dev_io : NAND_PINS_OUT.io_out;
    nfc_host dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
        .REQ_READY_OUT(REQ_READY_OUT), .DIN_VALID_IN(DIN_VALID_IN), .DIN_IN(DIN_IN), .DIN_READY_OUT(DIN_READY_OUT),
        .DOUT_OUT(DOUT_OUT), .DOUT_VALID_OUT(DOUT_VALID_OUT), .ECC_OUT(ECC_OUT), .ECC_VALID_OUT(ECC_VALID_OUT),
        .DONE_OUT(DONE_OUT), .FAIL_OUT(FAIL_OUT), .REFUSED_OUT(REFUSED_OUT), .NAND_PINS_OUT(NAND_PINS_OUT),
        .NAND_IO_IN(io), .NAND_RB_IN(rb));
    nfc_dev #(.ID_VAL(ID_VAL)) model (.CLK_IN(CLK_IN), .PINS_IN(NAND_PINS_OUT), .FAIL_BLK_IN(fail_blk),
        .IO_OUT(dev_io), .RB_OUT(rb));
    initial begin
        forever #2 CLK_IN = ~CLK_IN;
    end
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 7 + i / 256);
    endfunction
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // One request, feeding data with stalls and collecting bytes
    task automatic run(input nfc_pkg::nfc_op_type op, input logic [15:0] row);
        int cyc;
        logic tk, tr, done;
        nout = 0;
        necc = 0;
        k = 0;
        done = 1'b0;
        @(posedge CLK_IN);
        REQ_VALID_IN <= 1'b1;
        REQ_IN <= '{op, row};
        DIN_IN <= pat(0);
        for (cyc = 0; cyc < 40000 && !done; cyc++) begin
            @(negedge CLK_IN);
            tk = DIN_READY_OUT === 1'b1 && DIN_VALID_IN === 1'b1;
            tr = REQ_READY_OUT === 1'b1 && REQ_VALID_IN === 1'b1;
            done = DONE_OUT === 1'b1;
            if (DOUT_VALID_OUT === 1'b1 && nout < 2112) outb[nout] = DOUT_OUT;
            if (DOUT_VALID_OUT === 1'b1) nout++;
            if (ECC_VALID_OUT === 1'b1) necc++;
            if (ECC_VALID_OUT === 1'b1) ecc_seen = ECC_OUT;
            @(posedge CLK_IN);
            if (tr) REQ_VALID_IN <= 1'b0;
            if (tk) k++;
            if (tk) DIN_IN <= pat(k);
            if (tk || !DIN_VALID_IN) DIN_VALID_IN <= op == nfc_pkg::OP_PROGRAM && k < 2112 && cyc % 64 > 15;
        end
        if (!done) begin
            check("request done", 1, done);
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_id();
        int i;
        run(nfc_pkg::OP_READ_ID, 16'h0000);
        check("id cmd", 8'h90, model.cmd);
        check("id addr", 8'h00, model.adr[0]);
        check("id count", 5, nout);
        for (i = 0; i < 5; i++) check("id byte", ID_VAL[39 - 8 * i -: 8], outb[i]);
    endtask
    task automatic t_prog();
        int i, bad;
        bad = 0;
        run(nfc_pkg::OP_PROGRAM, 16'h00C5);
        check("addr0", 8'h00, model.adr[0]);
        check("addr1", 8'h00, model.adr[1]);
        check("addr2", 8'hC5, model.adr[2]);
        check("addr3", 8'h00, model.adr[3]);
        for (i = 0; i < 2112; i++) bad += model.mem[i] !== pat(i);
        check("page bytes", 0, bad);
        check("prog ecc", 4, necc);
        check("prog fail", 0, FAIL_OUT);
    endtask
    task automatic t_read();
        int i, bad;
        nfc_pkg::nfc_ecc_type e;
        bad = 0;
        e = '0;
        run(nfc_pkg::OP_READ_PAGE, 16'h00C5);
        for (i = 0; i < 2112; i++) bad += outb[i] !== pat(i);
        // Line and column parity of the last sector
        for (i = 1536; i < 2048; i++) begin
            e.cp = e.cp ^ pat(i);
            for (int b = 0; b < 9; b++) begin
                e.lp1[b] = e.lp1[b] ^ (i[b] & (^pat(i)));
                e.lp0[b] = e.lp0[b] ^ (!i[b] & (^pat(i)));
            end
        end
        check("read ecc code", e, ecc_seen);
        check("read count", 2112, nout);
        check("read bytes", 0, bad);
        check("read ecc", 4, necc);
    endtask
    task automatic t_order();
        run(nfc_pkg::OP_PROGRAM, 16'h00C5);
        check("same page", 1, REFUSED_OUT);
        run(nfc_pkg::OP_PROGRAM, 16'h00C4);
        check("lower page", 1, REFUSED_OUT);
        check("no data", 0, k);
    endtask
    task automatic t_fail();
        fail_blk <= 10'h007;
        run(nfc_pkg::OP_PROGRAM, 16'h01C9);
        check("status fail", 1, FAIL_OUT);
        check("new block", 0, REFUSED_OUT);
        run(nfc_pkg::OP_ERASE, 16'h01C0);
        check("retired", 1, REFUSED_OUT);
        run(nfc_pkg::OP_ERASE, 16'h00C0);
        check("erase ok", 0, REFUSED_OUT | FAIL_OUT);
        check("erase row", 8'hC0, model.adr[0]);
    endtask
    initial begin
        repeat (8) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        t_id();
        t_prog();
        t_read();
        t_order();
        t_fail();
        end_sim();
    end
endmodule // nfc_host_test
